// *** lvd_cmp_model.sv ***
// comparator and reference source model facing the detector control
`timescale 1ns/1ps
module lvd_cmp_model (
    input  wire logic        ext_i,   // external pin selected
    input  wire logic [3:0]  code_i,  // threshold code
    input  wire logic [12:0] vdd_i,   // supply in mV
    input  wire logic [12:0] pin_i,   // sense pin in mV
    output logic             below_o  // source below threshold
);
    function automatic int thr(input logic [3:0] c);
        int t[16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                      3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};
        return t[c];
    endfunction
    // raw analog stage ignores enable, so gating is up to the control
    assign below_o = ext_i ? (pin_i < 1210) : (vdd_i < thr(code_i));
endmodule

// *** lvd_ctrl.sv ***
// control logic of the low-voltage detector
//
// Summary of operation
// - reset clears the level register to zero, highest threshold
// - level code bits 3..0 pick one of sixteen thresholds, 0 highest
// - external source uses a fixed threshold, level field ignored
// - reset sets port 12 direction register to all ones
// - direction bits 0..4: 0 output, 1 input; bits 5..7 read 1
// - reset mode: internal reset while below threshold, released at/above
// - interrupt mode: raise interrupt request while source below threshold
// - control bit 2 selects source: 0 supply, 1 external pin
// - unmasked interrupt can fire only after the STAB_CNT settle cycles that follow setting enable
// - setting action while above threshold causes no reset
// - reset sets interrupt mask flag to one
// - detector reset sets reset cause bit 0
// - level and direction registers take bit and byte writes
// - control resets to zero: enable 7, source 2, action 1, flag 0
// - other resets clear enable, action, source; detector reset keeps them
// - flag drives interrupt request only when enabled and action is zero
`timescale 1ns/1ps
module lvd_ctrl
    import lvd_pkg::*;
#(
    parameter int STAB_CNT = STAB_CYCLES
) (
    input  wire logic              clk_sys_i,      // system clock
    input  wire logic              nrst_i,         // async chip reset, active low
    input  wire logic              lvd_rst_i,      // high when this reset came from the detector
    input  wire logic [15:0]       addr_i,         // cpu address
    input  wire logic              wr_i,           // write strobe
    input  wire logic              bit_wr_i,       // 1-bit write when high, byte write when low
    input  wire logic [2:0]        bit_sel_i,      // bit number of a 1-bit write
    input  wire logic [7:0]        wdata_i,        // byte data, or bit value in bit 0
    input  wire logic              irq_mask_wr_i,  // write strobe for the irq mask flag
    input  wire logic              irq_mask_i,     // irq mask value to write
    input  wire logic              below_i,        // comparator: source below threshold
    input  wire logic              cause_clr_i,    // reset cause register read clears
    output logic [7:0]             ctrl_o,         // detector control register readback
    output logic [7:0]             level_o,        // detect level register readback
    output logic [7:0]             p12dir_o,       // port 12 direction register readback
    output logic [LEVEL_W-1:0]     level_code_o,   // threshold code to the reference
    output logic                   src_ext_o,      // comparator uses external pin
    output logic                   cmp_en_o,       // comparator power enable
    output logic                   irq_o,          // low_voltage_irq request level
    output logic                   irq_mask_o,     // low_voltage_irq_mask flag
    output logic                   int_rst_o,      // internal reset request
    output logic                   cause_o         // low_voltage_reset_cause bit 0
);
    logic       en_ff, src_ff, act_ff, flag_ff, sync1_ff, sync2_ff, mask_ff, rst_ff, cause_ff;
    logic       nxt_en, nxt_src, nxt_act, nxt_flag, nxt_mask, nxt_rst, nxt_cause;
    logic [LEVEL_W-1:0]  lvl_ff, nxt_lvl;
    logic [P12_PINS-1:0] dir_ff, nxt_dir;
    logic [13:0] stab_ff, nxt_stab;
    logic        kept_ff;   // 1 after first edge: control bits captured on detector reset
    logic [7:0]  saved_ff, nxt_saved;
    logic        stable;

    // merge a bit or byte write into an old byte
    function automatic logic [7:0] merge(input logic [7:0] old, input logic bw,
                                          input logic [2:0] b, input logic [7:0] d);
        logic [7:0] r;
        r = old;
        if (bw) begin
            r[b] = d[0];
        end else begin
            r = d;
        end
        return r;
    endfunction

    logic [7:0] ctrl_w, lvl_w, dir_w;
    assign stable = (stab_ff == 14'(STAB_CNT));
    always_comb begin
        ctrl_w  = merge({en_ff, 4'h0, src_ff, act_ff, flag_ff}, bit_wr_i, bit_sel_i, wdata_i);
        lvl_w   = merge({4'h0, lvl_ff}, bit_wr_i, bit_sel_i, wdata_i);
        dir_w   = merge({3'h7, dir_ff}, bit_wr_i, bit_sel_i, wdata_i);
        nxt_en  = en_ff;
        nxt_src = src_ff;
        nxt_act = act_ff;
        nxt_lvl = lvl_ff;
        nxt_dir = dir_ff;
        if (wr_i && addr_i == ADDR_CTRL) begin
            nxt_en  = ctrl_w[BIT_ENABLE];
            nxt_src = ctrl_w[BIT_SOURCE];
            nxt_act = ctrl_w[BIT_ACTION];
        end
        if (wr_i && addr_i == ADDR_LEVEL && !en_ff) begin
            nxt_lvl = lvl_w[LEVEL_W-1:0];
        end
        if (wr_i && addr_i == ADDR_P12DIR) begin
            nxt_dir = dir_w[P12_PINS-1:0];
        end
        // detector reset: restore control bits saved before reset
        if (!kept_ff && lvd_rst_i) begin
            nxt_en  = saved_ff[BIT_ENABLE];
            nxt_src = saved_ff[BIT_SOURCE];
            nxt_act = saved_ff[BIT_ACTION];
        end
        // comparator result gated by enable and settle time
        nxt_stab = en_ff ? (stable ? stab_ff : stab_ff + 14'h1) : 14'h0;
        nxt_flag = en_ff && stable && sync2_ff;
        nxt_mask = irq_mask_wr_i ? irq_mask_i : mask_ff;
        nxt_rst  = en_ff && act_ff && flag_ff;
        // frozen while reset is low, else the reset values would overwrite the copy
        nxt_saved = nrst_i ? {en_ff, 4'h0, src_ff, act_ff, 1'b0} : saved_ff;
        nxt_cause = !nrst_i ? cause_ff : (rst_ff ? 1'b1 : (cause_clr_i ? 1'b0 : cause_ff));
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_ff    <= 1'b0;
            src_ff   <= 1'b0;
            act_ff   <= 1'b0;
            flag_ff  <= 1'b0;
            lvl_ff   <= LEVEL_RESET[LEVEL_W-1:0];
            dir_ff   <= P12DIR_RESET[P12_PINS-1:0];
            stab_ff  <= 14'h0;
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            mask_ff  <= 1'b1;
            rst_ff   <= 1'b0;
            kept_ff  <= 1'b0;
        end else begin
            kept_ff  <= 1'b1;
            en_ff    <= nxt_en;
            src_ff   <= nxt_src;
            act_ff   <= nxt_act;
            flag_ff  <= nxt_flag;
            lvl_ff   <= nxt_lvl;
            dir_ff   <= nxt_dir;
            stab_ff  <= nxt_stab;
            sync1_ff <= below_i;
            sync2_ff <= sync1_ff;
            mask_ff  <= nxt_mask;
            rst_ff   <= nxt_rst;
        end
    end

    // survives the chip reset so a detector reset keeps the control bits
    always_ff @(posedge clk_sys_i) begin
        saved_ff <= nxt_saved;
        cause_ff <= nxt_cause;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_o       <= CTRL_RESET;
            level_o      <= LEVEL_RESET;
            p12dir_o     <= P12DIR_RESET;
            level_code_o <= '0;
            src_ext_o    <= 1'b0;
            cmp_en_o     <= 1'b0;
            irq_o        <= 1'b0;
            irq_mask_o   <= 1'b1;
            int_rst_o    <= 1'b0;
            cause_o      <= 1'b0;
        end else begin
            ctrl_o       <= {en_ff, 4'h0, src_ff, act_ff, flag_ff};
            level_o      <= {4'h0, lvl_ff};
            p12dir_o     <= {3'h7, dir_ff};
            level_code_o <= lvl_ff;
            src_ext_o    <= src_ff;
            cmp_en_o     <= en_ff;
            irq_o        <= flag_ff && en_ff && !act_ff;
            irq_mask_o   <= mask_ff;
            int_rst_o    <= rst_ff;
            cause_o      <= cause_ff;
        end
    end

    // detection path steps: settled comparator, flag, then request
    sequence s_cmp_valid;
        en_ff && stable && sync2_ff;
    endsequence
    sequence s_irq_cond;
        flag_ff && en_ff && !act_ff;
    endsequence
    sequence s_rst_cond;
        en_ff && act_ff && flag_ff;
    endsequence

    a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        irq_o |-> $past(en_ff) && !$past(act_ff)) else $error("irq outside interrupt mode");
    a_rst_follow: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_rst_cond |-> ##2 int_rst_o) else $error("reset not raised");
    a_no_rst_above: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!flag_ff) |-> ##2 !int_rst_o) else $error("reset above threshold");
    a_level_lock: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        en_ff |=> $stable(lvl_ff)) else $error("level changed while enabled");
    a_flag_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !en_ff |=> !flag_ff) else $error("flag set while disabled");
    a_dir_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        p12dir_o[7:5] == 3'h7) else $error("direction top bits not one");
    a_cause_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        rst_ff |=> cause_ff) else $error("reset cause not set");
    a_level_top: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        level_o[7:4] == 4'h0) else $error("level top bits not zero");
    a_flag_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_cmp_valid |=> flag_ff) else $error("flag missed comparator");
    a_irq_raise: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_irq_cond |=> irq_o) else $error("interrupt request not raised");
    a_irq_drop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !flag_ff |=> !irq_o) else $error("interrupt request without flag");
    a_stab_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (en_ff && !stable) |=> !flag_ff) else $error("flag before settle time");
    a_rst_mode: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        int_rst_o |-> $past(act_ff, 2)) else $error("reset outside reset mode");
    a_cause_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (cause_clr_i && !rst_ff) |=> !cause_ff) else $error("reset cause not cleared");
    a_src_copy: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        src_ext_o == $past(src_ff)) else $error("source select not passed on");
    a_en_copy: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        cmp_en_o == $past(en_ff)) else $error("comparator enable not passed on");
    a_mask_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        irq_mask_wr_i |=> (mask_ff == $past(irq_mask_i))) else $error("mask write lost");

    // byte writes land whole in the implemented bits
    a_dir_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_i && !bit_wr_i && addr_i == ADDR_P12DIR) |=> (dir_ff == $past(wdata_i[P12_PINS-1:0])))
        else $error("direction byte write lost");
    a_level_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_i && !bit_wr_i && addr_i == ADDR_LEVEL && !en_ff) |=> (lvl_ff == $past(wdata_i[LEVEL_W-1:0])))
        else $error("level byte write lost");
endmodule

// *** lvd_ctrl_test.sv ***
// self-checking bench for the detector control block
`timescale 1ns/1ps
module lvd_ctrl_test import lvd_pkg::*; ();
    logic        clk_sys_i = 0, nrst_i = 0, lvd_rst_i = 0, wr_i = 0, bit_wr_i = 0;
    logic        irq_mask_wr_i = 0, irq_mask_i = 1, below_i, cause_clr_i = 0;
    logic [15:0] addr_i = 16'h0000;
    logic [2:0]  bit_sel_i = 3'h0;
    logic [7:0]  wdata_i = 8'h00, ctrl_o, level_o, p12dir_o, e, lv = 8'h00, pd = 8'hFF;
    logic [3:0]  level_code_o;
    logic        src_ext_o, cmp_en_o, irq_o, irq_mask_o, int_rst_o, cause_o;
    logic [12:0] vdd = 13'h1388, pin = 13'h07D0;
    logic [31:0] seed = 32'hB7840EA9, r;
    int          num_errors = 0, checks = 0;
    wire  [3:0]  obs = {cause_o, int_rst_o, irq_o, ctrl_o[0]};
    always #2.5 clk_sys_i = ~clk_sys_i;
    lvd_ctrl #(.STAB_CNT(8)) dut (.clk_sys_i, .nrst_i, .lvd_rst_i, .addr_i, .wr_i, .bit_wr_i,
        .bit_sel_i, .wdata_i, .irq_mask_wr_i, .irq_mask_i, .below_i, .cause_clr_i, .ctrl_o,
        .level_o, .p12dir_o, .level_code_o, .src_ext_o, .cmp_en_o, .irq_o, .irq_mask_o,
        .int_rst_o, .cause_o);
    lvd_cmp_model cmp (.ext_i(src_ext_o), .code_i(level_code_o), .vdd_i(vdd), .pin_i(pin),
        .below_o(below_i));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic exp_below(input logic [3:0] c, input logic x);
        int t[16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                      3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};
        return x ? (pin < 1210) : (vdd < t[c]);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ends on the second falling edge after the taking edge so readback has settled
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 0,
                      input logic [2:0] s = 3'h0);
        addr_i = a;
        wdata_i = d;
        bit_wr_i = b;
        bit_sel_i = s;
        wr_i = 1;
        @(negedge clk_sys_i);
        wr_i = 0;
        @(negedge clk_sys_i);
    endtask
    task automatic wt(input int i, input logic x);
        repeat (40) if (obs[i] !== x) @(negedge clk_sys_i);
        chk({7'h00, obs[i]}, {7'h00, x});
        if (obs[i] !== x) test_done();
    endtask
    task automatic rst(input logic lr);
        nrst_i = 0;
        lvd_rst_i = lr;
        repeat (5) @(negedge clk_sys_i);
        nrst_i = 1;
        @(negedge clk_sys_i);
        lvd_rst_i = 0;
        @(negedge clk_sys_i);
    endtask
    task automatic test_done();
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        test_done();
    end
    initial begin
        rst(1'b0);
        chk(ctrl_o, 8'h00);
        chk(level_o, 8'h00);
        chk(p12dir_o, 8'hFF);
        chk({5'h00, irq_mask_o, irq_o, int_rst_o}, 8'h04);
        for (int k = 0; k < 14; k++) begin
            r = xs();
            e = r[8] ? lv : pd;
            if (r[9]) e[r[12:10]] = r[0];
            else e = r[7:0];
            wr(k == 13 ? 16'hFFBD : (r[8] ? ADDR_LEVEL : ADDR_P12DIR), r[7:0], r[9], r[12:10]);
            if (k == 13) e = 8'h00;
            else if (r[8]) lv = e & 8'h0F;
            else pd = e | 8'hE0;
            chk(level_o, lv);
            chk(p12dir_o, pd);
        end
        wr(ADDR_P12DIR, 8'h01, 1'b1, 3'h0);
        chk(p12dir_o, pd | 8'h01);
        for (int k = 0; k < 8; k++) begin
            r = xs();
            vdd = 13'd1800 + 13'(r[11:0] % 12'd2700);
            pin = 13'd1000 + 13'(r[20:12]);
            wr(ADDR_LEVEL, {4'h0, r[27:24]});
            wr(ADDR_CTRL, {1'b1, 4'h0, r[28], 2'b00});
            chk(ctrl_o & 8'h01, 8'h00);
            wr(ADDR_LEVEL, 8'h0F);
            chk(level_o, {4'h0, r[27:24]});
            chk({4'h0, level_code_o}, {4'h0, r[27:24]});
            wt(0, exp_below(r[27:24], r[28]));
            wt(1, exp_below(r[27:24], r[28]));
            wr(ADDR_CTRL, 8'h00);
            wt(0, 1'b0);
        end
        vdd = 13'd5000;
        wr(ADDR_CTRL, 8'h80);
        repeat (12) @(negedge clk_sys_i);
        wr(ADDR_CTRL, 8'h82);
        repeat (6) @(negedge clk_sys_i);
        chk({7'h00, int_rst_o}, 8'h00);
        vdd = 13'd1000;
        wt(2, 1'b1);
        wt(3, 1'b1);
        chk({7'h00, irq_o}, 8'h00);
        vdd = 13'd5000;
        wt(2, 1'b0);
        rst(1'b1);
        chk(ctrl_o & 8'hFE, 8'h82);
        chk({7'h00, cause_o}, 8'h01);
        cause_clr_i = 1;
        @(negedge clk_sys_i);
        cause_clr_i = 0;
        wt(3, 1'b0);
        wr(ADDR_CTRL, 8'h00, 1'b1, 3'h1);
        wr(ADDR_CTRL, 8'h00, 1'b1, 3'h7);
        chk(ctrl_o, 8'h00);
        for (int m = 0; m < 2; m++) begin
            irq_mask_i = m[0];
            irq_mask_wr_i = 1;
            @(negedge clk_sys_i);
            irq_mask_wr_i = 0;
            @(negedge clk_sys_i);
            chk({7'h00, irq_mask_o}, {7'h00, m[0]});
        end
        pin = 13'h3E8;
        wr(ADDR_CTRL, 8'h01, 1'b1, 3'h2);
        wr(ADDR_CTRL, 8'h01, 1'b1, 3'h7);
        repeat (4) @(negedge clk_sys_i);
        chk(ctrl_o & 8'h01, 8'h00);
        wt(0, 1'b1);
        wt(1, 1'b1);
        chk({6'h00, cmp_en_o, src_ext_o}, 8'h03);
        pin = 13'h5DC;
        wt(0, 1'b0);
        wr(ADDR_CTRL, 8'h01, 1'b1, 3'h1);
        repeat (6) @(negedge clk_sys_i);
        chk({7'h00, int_rst_o}, 8'h00);
        pin = 13'h3E8;
        wt(2, 1'b1);
        pin = 13'h5DC;
        wt(2, 1'b0);
        rst(1'b0);
        chk(ctrl_o, 8'h00);
        test_done();
    end
endmodule

// *** lvd_pkg.sv ***
// constants for the low-voltage detector control block
package lvd_pkg;
    localparam logic [15:0] ADDR_CTRL      = 16'hFFBE;
    localparam logic [15:0] ADDR_LEVEL     = 16'hFFBF;
    localparam logic [15:0] ADDR_P12DIR    = 16'hFF2C;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  LEVEL_RESET    = 8'h00;
    localparam logic [7:0]  P12DIR_RESET   = 8'hFF;
    localparam int          BIT_ENABLE     = 7;
    localparam int          BIT_SOURCE     = 2;
    localparam int          BIT_ACTION     = 1;
    localparam int          BIT_FLAG       = 0;
    localparam int          LEVEL_W        = 4;
    localparam int          P12_PINS       = 5;
    localparam int          CLK_MHZ        = 200;
    localparam int          STAB_TIME_NS   = 10000;
    localparam int          STAB_CYCLES    = (STAB_TIME_NS * CLK_MHZ) / 1000;
endpackage
